// *** hw/bmg_regs.vh ***
/*
 * Register offsets, field codes, limits and reset values for the
 * baseband marker generator.
 * Assumes it is included by bare name by every design file using it.
 */
`ifndef BMG_REGS_VH
`define BMG_REGS_VH

// Byte offsets inside one marker's 32-byte window
`define BMG_OFS_TYPE 5'h00
`define BMG_OFS_PERIOD 5'h04
`define BMG_OFS_LOW 5'h08
`define BMG_OFS_HIGH 5'h0C
`define BMG_OFS_SEQ_LO 5'h10
`define BMG_OFS_SEQ_HI 5'h14
`define BMG_OFS_SEQ_LEN 5'h18

// Global status word, above the four marker windows
`define BMG_ADDR_STATUS 8'h80

// Marker type codes
`define BMG_TYPE_FILE 2'h0
`define BMG_TYPE_SQUARE 2'h1
`define BMG_TYPE_SEQ 2'h2
`define BMG_TYPE_RATIO 2'h3
`define BMG_RST_TYPE 2'h1

// Square output period limits and reset
`define BMG_PERIOD_MIN 11'h002
`define BMG_PERIOD_MAX 11'h400
`define BMG_RST_PERIOD 11'h002

// On/off sample counts: 24-bit field, zero refused
`define BMG_CNT_MIN 24'h000001
`define BMG_RST_CNT 24'h000001

// Sequence length limits, reset length and value
`define BMG_LEN_MIN 7'h01
`define BMG_LEN_MAX 7'h40
`define BMG_RST_LEN 7'h02
`define BMG_RST_SEQ 64'h0000000000000002

// Sign flag position in the sequence length write
`define BMG_NEG_BIT 31

`endif

// *** hw/bmg_marker_chan.v ***
/*
 * One marker channel: turns the settings of one marker into a
 * marker bit that advances once per baseband sample.
 * Assumes settings are already range checked and stable, and that
 * restart pulses for one cycle after any setting changes.
 */
`timescale 1ns/10ps
`include "bmg_regs.vh"

module bmg_marker_chan (
    input wire clk_sys,
    input wire rstnSync,
    input wire sampleStb,
    input wire restart,
    input wire [1:0] mode,
    input wire [10:0] period,
    input wire [23:0] lowCnt,
    input wire [23:0] highCnt,
    input wire [63:0] seq,
    input wire [6:0] seqLen,
    input wire fileBit,
    output wire markOut
);

////////////////////////////////////////////////////////////////////////
// Counters and derived limits
reg [23:0] cntQ; // Sample position within current phase
reg phaseQ; // High phase of on/off ratio
reg markQ; // Marker bit, registered
wire [23:0] perLast = {13'h0, period} - 24'h1;
wire [23:0] halfPer = {14'h0, period[10:1]};
wire [6:0] seqLast = seqLen - 7'h1;
// Index of the next bit, MSB of the used part first
wire [6:0] bitIdx = seqLast - cntQ[6:0];

////////////////////////////////////////////////////////////////////////
// Marker sequencing, one step per sample strobe
always @(posedge clk_sys or negedge rstnSync) begin
    if (!rstnSync) begin
        cntQ <= 24'h0;
        phaseQ <= 1'b1;
        markQ <= 1'b0;
    end else if (restart) begin
        // New settings start cleanly from the first sample
        cntQ <= 24'h0;
        phaseQ <= 1'b1;
    end else if (sampleStb) begin
        case (mode)
            `BMG_TYPE_SQUARE: begin
                // High for first half period, low for the rest
                markQ <= (cntQ < halfPer);
                cntQ <= (cntQ >= perLast) ? 24'h0 : cntQ + 24'h1;
            end
            `BMG_TYPE_RATIO: begin
                markQ <= phaseQ;
                if (phaseQ) begin
                    if (cntQ >= highCnt - 24'h1) begin
                        cntQ <= 24'h0;
                        phaseQ <= 1'b0;
                    end else begin
                        cntQ <= cntQ + 24'h1;
                    end
                end else begin
                    if (cntQ >= lowCnt - 24'h1) begin
                        cntQ <= 24'h0;
                        phaseQ <= 1'b1;
                    end else begin
                        cntQ <= cntQ + 24'h1;
                    end
                end
            end
            `BMG_TYPE_SEQ: begin
                markQ <= seq[bitIdx[5:0]];
                // Wrap to first bit after the last one
                if (cntQ[6:0] >= seqLast) begin
                    cntQ <= 24'h0;
                end else begin
                    cntQ <= cntQ + 24'h1;
                end
            end
            `BMG_TYPE_FILE: begin
                // Bit comes from the file playback path
                markQ <= fileBit;
                cntQ <= 24'h0;
            end
            default: begin
                markQ <= 1'b0;
            end
        endcase
    end
end

assign markOut = markQ;

endmodule // bmg_marker_chan

// *** hw/bmg_marker_gen.v ***
/*
 * Baseband marker generator top: reset synchroniser, register port
 * with the settings of four markers, and four marker channels.
 * Assumes sampleStb and markerFileBit come from logic on clk_sys,
 * and that the register master keeps the plain strobe protocol.
 */
`timescale 1ns/10ps
`include "bmg_regs.vh"

module bmg_marker_gen #(
    parameter NUM_MARKERS = 4
) (
    input wire clk_sys,
    input wire rstn,
    input wire [7:0] regAddr,
    input wire [31:0] regWrData,
    input wire regWrEn,
    input wire regRdEn,
    output wire [31:0] regRdData,
    input wire sampleStb,
    input wire [3:0] markerFileBit,
    output wire [3:0] markerOut
);

////////////////////////////////////////////////////////////////////////
// Reset synchroniser
// Release is synchronous so no flop sees a late edge
reg rstnMetaQ; // First stage, read only by second
reg rstnSyncQ; // Reset copy used everywhere else

// Two flops on the release edge
always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        rstnMetaQ <= 1'b0;
        rstnSyncQ <= 1'b0;
    end else begin
        rstnMetaQ <= 1'b1;
        rstnSyncQ <= rstnMetaQ;
    end
end

////////////////////////////////////////////////////////////////////////
// Shared decode of the incoming write
// Marker windows sit below the status word
wire inMarkers = ~regAddr[7]; // Address in a marker window
wire [4:0] ofs = regAddr[4:0]; // Offset inside window

// Sequence length field and sign flag of a commit
wire [6:0] lenIn = regWrData[6:0];
wire negIn = regWrData[`BMG_NEG_BIT];
wire lenOk = (lenIn >= `BMG_LEN_MIN) && (lenIn <= `BMG_LEN_MAX);

// Mask of the used bits, 64 is special to avoid overflow
wire [63:0] maskIn = (lenIn == `BMG_LEN_MAX) ?
    64'hFFFFFFFFFFFFFFFF : ((64'h1 << lenIn) - 64'h1);
// Top used bit, where a negative value sets a one
wire [63:0] msbIn = 64'h1 << (lenIn - 7'h1);

// Range checks on the other numeric settings
wire [10:0] perIn = regWrData[10:0];
wire perOk = (regWrData[31:11] == 21'h0) &&
    (perIn >= `BMG_PERIOD_MIN) && (perIn <= `BMG_PERIOD_MAX);
wire [23:0] cntIn = regWrData[23:0];
wire cntOk = (regWrData[31:24] == 8'h0) && (cntIn >= `BMG_CNT_MIN);

// Read words of every marker, flattened
wire [32*NUM_MARKERS-1:0] rdMk;

////////////////////////////////////////////////////////////////////////
// Per-marker settings and channel
genvar gi;
generate
    for (gi = 0; gi < NUM_MARKERS; gi = gi + 1) begin : gMk
        localparam [31:0] IDX = gi; // Window number, full width
        // Write targets this marker's window
        wire wrHit = regWrEn && inMarkers && (regAddr[6:5] == IDX[1:0]);

        reg [1:0] modeQ; // Marker type
        reg [10:0] periodQ; // Square period in samples
        reg [23:0] lowQ; // Low sample count
        reg [23:0] highQ; // High sample count
        reg [63:0] stageQ; // Value waiting for a length commit
        reg [63:0] seqQ; // Stored sequence, masked
        reg [6:0] lenQ; // Sequence length in use
        reg restartQ; // Realign channel after a write
        reg [31:0] rdSel; // Read word of this window

        // Setting registers
        // Out-of-range values are dropped, old value stays
        always @(posedge clk_sys or negedge rstnSyncQ) begin
            if (!rstnSyncQ) begin
                modeQ <= `BMG_RST_TYPE;
                periodQ <= `BMG_RST_PERIOD;
                lowQ <= `BMG_RST_CNT;
                highQ <= `BMG_RST_CNT;
                stageQ <= 64'h0;
                seqQ <= `BMG_RST_SEQ;
                lenQ <= `BMG_RST_LEN;
                restartQ <= 1'b0;
            end else begin
                restartQ <= wrHit;
                if (wrHit) begin
                    case (ofs)
                        `BMG_OFS_TYPE: begin
                            modeQ <= regWrData[1:0];
                        end
                        `BMG_OFS_PERIOD: begin
                            if (perOk) begin
                                periodQ <= perIn;
                            end
                        end
                        `BMG_OFS_LOW: begin
                            if (cntOk) begin
                                lowQ <= cntIn;
                            end
                        end
                        `BMG_OFS_HIGH: begin
                            if (cntOk) begin
                                highQ <= cntIn;
                            end
                        end
                        `BMG_OFS_SEQ_LO: begin
                            stageQ[31:0] <= regWrData;
                        end
                        `BMG_OFS_SEQ_HI: begin
                            stageQ[63:32] <= regWrData;
                        end
                        `BMG_OFS_SEQ_LEN: begin
                            // Commit: truncate or zero-fill,
                            // then force MSB for negatives
                            if (lenOk) begin
                                lenQ <= lenIn;
                                seqQ <= (stageQ & maskIn) |
                                    (negIn ? msbIn : 64'h0);
                            end
                        end
                        default: begin
                            // Unmapped offsets write nothing
                        end
                    endcase
                end
            end
        end

        // Read word selection
        // Value reads back as stored hex, length beside it
        always @* begin
            case (ofs)
                `BMG_OFS_TYPE: rdSel = {30'h0, modeQ};
                `BMG_OFS_PERIOD: rdSel = {21'h0, periodQ};
                `BMG_OFS_LOW: rdSel = {8'h0, lowQ};
                `BMG_OFS_HIGH: rdSel = {8'h0, highQ};
                `BMG_OFS_SEQ_LO: rdSel = seqQ[31:0];
                `BMG_OFS_SEQ_HI: rdSel = seqQ[63:32];
                `BMG_OFS_SEQ_LEN: rdSel = {25'h0, lenQ};
                default: rdSel = 32'h0;
            endcase
        end
        assign rdMk[32*gi +: 32] = rdSel;

        // Marker channel
        bmg_marker_chan uChan (
            .clk_sys(clk_sys),
            .rstnSync(rstnSyncQ),
            .sampleStb(sampleStb),
            .restart(restartQ),
            .mode(modeQ),
            .period(periodQ),
            .lowCnt(lowQ),
            .highCnt(highQ),
            .seq(seqQ),
            .seqLen(lenQ),
            .fileBit(markerFileBit[gi]),
            .markOut(markerOut[gi])
        );
    end
endgenerate

////////////////////////////////////////////////////////////////////////
// Read data register
// Data stand only in the cycle after the read strobe, zero otherwise,
// so a stale word can never be taken for a fresh one
reg [31:0] rdDataQ; // Registered read word
reg [31:0] rdData_d; // Next read word

// Address decode of the read
always @* begin
    rdData_d = 32'h0;
    if (regRdEn) begin
        if (regAddr == `BMG_ADDR_STATUS) begin
            // Live marker levels
            rdData_d = {28'h0, markerOut};
        end else if (inMarkers) begin
            rdData_d = rdMk[{regAddr[6:5], 5'h00} +: 32];
        end else begin
            // Unmapped reads return zero
            rdData_d = 32'h0;
        end
    end
end

// Read word flop
always @(posedge clk_sys or negedge rstnSyncQ) begin
    if (!rstnSyncQ) begin
        rdDataQ <= 32'h0;
    end else begin
        rdDataQ <= rdData_d;
    end
end

assign regRdData = rdDataQ;

endmodule // bmg_marker_gen

// *** dv/bmg_marker_gen_sva.sv ***
/* Port checker for the marker generator.
   Assumes it is bound onto bmg_marker_gen. */
`timescale 1ns/10ps
module bmg_marker_gen_sva (
    input wire clk_sys,
    input wire rstn,
    input wire [7:0] regAddr,
    input wire [31:0] regWrData,
    input wire regWrEn,
    input wire regRdEn,
    input wire [31:0] regRdData,
    input wire sampleStb,
    input wire [3:0] markerFileBit,
    input wire [3:0] markerOut
);
    // Read of a marker window, and its offset
    wire win = regRdEn && !regAddr[7];
    wire [4:0] ofs = regAddr[4:0];
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    //////////////////////////////////////////
    rd_stands_a: assert property (
        !regRdEn |=> regRdData == 32'h0) else $error("stale read data");
    mark_hold_a: assert property (
        !sampleStb |=> $stable(markerOut)) else $error("marker moved");
    status_echo_a: assert property (
        regRdEn && regAddr == 8'h80 |=>
        regRdData == {28'h0, $past(markerOut)}) else $error("bad status");
    type_width_a: assert property (
        win && ofs == 5'h00 |=> regRdData[31:2] == 30'h0)
        else $error("bad type");
    period_range_a: assert property (
        win && ofs == 5'h04 |=> regRdData >= 32'h2 && regRdData <= 32'h400)
        else $error("period out of range");
    count_range_a: assert property (
        win && (ofs == 5'h08 || ofs == 5'h0C) |=>
        regRdData[31:24] == 8'h0 && regRdData != 32'h0)
        else $error("count out of range");
    len_range_a: assert property (
        win && ofs == 5'h18 |=> regRdData inside {[32'h1:32'h40]})
        else $error("length out of range");
    unmapped_zero_a: assert property (
        regRdEn && (ofs == 5'h1C || regAddr > 8'h80) |=> regRdData == 32'h0)
        else $error("unmapped read not zero");
    // Main scenarios reached
    cover property ($rose(markerOut[0]));
    cover property (regWrEn && ofs == 5'h18 && regWrData[31]);
    cover property (sampleStb && regRdEn);
endmodule // bmg_marker_gen_sva

bind bmg_marker_gen bmg_marker_gen_sva u_sva (.clk_sys(clk_sys),
    .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .sampleStb(sampleStb), .markerFileBit(markerFileBit),
    .markerOut(markerOut));

// *** dv/bmg_sample_src.sv ***
/* Baseband sample source: strobe and file marker bits.
   Assumes run and slow come from the bench on clk_sys. */
`timescale 1ns/10ps
module bmg_sample_src (
    input wire clk_sys,
    input wire run,
    input wire slow,
    output reg sampleStb,
    output reg [3:0] fileBit
);
    reg phase_q; // Alternates for the slow rate
    initial begin
        phase_q = 1'b0;
        sampleStb = 1'b0;
        fileBit = 4'h1;
    end
    // Strobe each cycle or every other; file bits shift every cycle, each bit holding four cycles
    always @(posedge clk_sys) begin
        phase_q <= !phase_q;
        sampleStb <= run && (!slow || phase_q);
        fileBit <= {fileBit[2:0], ~fileBit[3]};
    end
endmodule // bmg_sample_src

// *** dv/bmg_marker_gen_test.sv ***
/* Self-checking bench for the marker generator.
   Assumes the sample source model and the bound checker. */
`timescale 1ns/10ps
module bmg_marker_gen_test;
    reg clk_sys, rstn, regWrEn, regRdEn, run, slow, rdSeen, stSeen, fb;
    reg anySt, par; // Any sample step, and parity of steps so far
    reg [7:0] regAddr, b;
    reg [31:0] regWrData;
    wire [31:0] regRdData;
    wire sampleStb;
    wire [3:0] markerFileBit, markerOut;
    reg [15:0] rnd;
    reg [1:0] e;
    reg [63:0] v, m, x;
    integer err_count, n_tests, i;
    reg [31:0] rdQ[$]; // Expected read words
    reg [1:0] mkQ[$]; // Expected marker bits, 2 means file bit
    bmg_marker_gen u_dut (.clk_sys(clk_sys), .rstn(rstn),
        .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regRdData(regRdData), .sampleStb(sampleStb),
        .markerFileBit(markerFileBit), .markerOut(markerOut));
    bmg_sample_src u_src (.clk_sys(clk_sys), .run(run), .slow(slow),
        .sampleStb(sampleStb), .fileBit(markerFileBit));
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    //////////////////////////////////////////
    function [15:0] lfsr(input [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task cmp(input [31:0] got, input [31:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Marker levels, one bit per marker
    task cmp_mk(input [3:0] got, input [3:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("CHECK FAILED %0t marker %h exp %h", $time, got, exp);
        end
    endtask
    // One bus cycle; a read notes d as its expected word
    task acc(input w, input [7:0] a, input [31:0] d);
        regWrEn <= w;
        regRdEn <= !w;
        regAddr <= a;
        regWrData <= d;
        if (!w) rdQ.push_back(d);
        @(posedge clk_sys);
    endtask
    task idle;
        regWrEn <= 1'b0;
        regRdEn <= 1'b0;
        @(posedge clk_sys);
    endtask
    task pm(input [1:0] s, input integer n);
        repeat (n) mkQ.push_back(s);
    endtask
    // Let samples flow until every noted marker bit is seen
    task go(input sl);
        integer j;
        j = 0;
        run <= 1'b1;
        slow <= sl;
        while (mkQ.size() > 0 && j < 400) begin
            @(posedge clk_sys);
            j = j + 1;
        end
        run <= 1'b0;
        repeat (3) @(posedge clk_sys);
        $display("test step done at %0t", $time);
        // Steps that never came count as a failure
        if (mkQ.size() > 0) begin
            err_count = err_count + 1;
            $display("CHECK FAILED %0t marker steps missing", $time);
            complete_run;
        end
    endtask
    // Refused values keep the old one, the good one is taken
    task rng(input [7:0] a, input [31:0] b1, b2, ok, old);
        acc(1'b1, a, b1);
        acc(1'b0, a, old);
        acc(1'b1, a, b2);
        acc(1'b0, a, old);
        acc(1'b1, a, ok);
        acc(1'b0, a, ok);
        $display("range step done at %0t", $time);
    endtask
    task sq(input [6:0] n, input ng);
        integer j;
        for (j = 0; j < 4; j = j + 1) begin
            rnd = lfsr(rnd);
            v = {v[47:0], rnd};
        end
        m = (n == 7'h40) ? ~64'h0 : (64'h1 << n) - 64'h1;
        x = (v & m) | (ng ? 64'h1 << (n - 7'h01) : 64'h0);
        acc(1'b1, 8'h00, 32'h2);
        acc(1'b1, 8'h10, v[31:0]);
        acc(1'b1, 8'h14, v[63:32]);
        acc(1'b1, 8'h18, {ng, 24'h0, n});
        acc(1'b0, 8'h10, x[31:0]);
        acc(1'b0, 8'h14, x[63:32]);
        acc(1'b0, 8'h18, {25'h0, n});
        idle;
        for (j = 0; j < 2 * n; j = j + 1) pm({1'b0, x[n - 1 - j % n]}, 1);
        go(ng);
    endtask
    //////////////////////////////////////////
    // Checks each read word and each marker step
    always @(posedge clk_sys) begin
        rdSeen = regRdEn;
        stSeen = sampleStb && mkQ.size() > 0;
        anySt = sampleStb;
        fb = markerFileBit[0];
        #1;
        if (rdSeen) cmp(regRdData, rdQ.pop_front());
        if (stSeen) begin
            e = mkQ.pop_front();
            cmp_mk({3'h0, markerOut[0]}, {3'h0, e[1] ? fb : e[0]});
        end
        // Markers 1..3 keep reset square, period 2: toggle each step
        if (anySt) begin
            par = !par;
            cmp_mk({1'b0, markerOut[3:1]}, {1'b0, {3{par}}});
        end
    end
    task complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        #60000;
        err_count = err_count + 1;
        complete_run;
    end
    initial begin
        {rstn, regWrEn, regRdEn, run, slow} = 5'h00;
        {regAddr, regWrData, v} = 104'h0;
        rnd = 16'h0055;
        par = 1'b0;
        err_count = 0;
        n_tests = 0;
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        for (i = 0; i < 4; i = i + 1) begin
            b = {1'b0, i[1:0], 5'h00};
            acc(1'b0, b, 32'h1);
            acc(1'b0, b + 8'h04, 32'h2);
            acc(1'b0, b + 8'h08, 32'h1);
            acc(1'b0, b + 8'h0C, 32'h1);
            acc(1'b0, b + 8'h10, 32'h2);
            acc(1'b0, b + 8'h14, 32'h0);
            acc(1'b0, b + 8'h18, 32'h2);
        end
        acc(1'b0, 8'h1C, 32'h0);
        acc(1'b0, 8'h84, 32'h0);
        acc(1'b0, 8'h80, 32'h0);
        acc(1'b1, 8'h04, 32'h2);
        idle;
        pm(2'h1, 1);
        pm(2'h0, 1);
        pm(2'h1, 1);
        pm(2'h0, 1);
        go(1'b0);
        acc(1'b1, 8'h00, 32'h2);
        idle;
        for (i = 0; i < 4; i = i + 1) pm({1'b0, i[0] == 1'b0}, 1);
        go(1'b1);
        rng(8'h04, 32'h1, 32'h802, 32'h400, 32'h2);
        rng(8'h08, 32'h0, 32'h1000001, 32'hFFFFFF, 32'h1);
        rng(8'h0C, 32'h0, 32'h1000001, 32'hFFFFFF, 32'h1);
        rng(8'h18, 32'h0, 32'h41, 32'h40, 32'h2);
        sq(7'h01, 1'b0);
        sq(7'h05, 1'b0);
        sq(7'h40, 1'b0);
        sq(7'h04, 1'b1);
        acc(1'b1, 8'h00, 32'h3);
        acc(1'b1, 8'h0C, 32'h3);
        acc(1'b1, 8'h08, 32'h2);
        idle;
        for (i = 0; i < 2; i = i + 1) begin
            pm(2'h1, 3);
            pm(2'h0, 2);
        end
        go(1'b1);
        acc(1'b1, 8'h00, 32'h1);
        acc(1'b1, 8'h04, 32'h5);
        idle;
        for (i = 0; i < 2; i = i + 1) begin
            pm(2'h1, 2);
            pm(2'h0, 3);
        end
        go(1'b0);
        acc(1'b1, 8'h00, 32'h0);
        idle;
        pm(2'h2, 8);
        go(1'b0);
        complete_run;
    end
endmodule // bmg_marker_gen_test
